// file: src/kgd_pkg.sv
// Package for the keypad result, DAC input and GPIO data registers.
// Assumes a 16-bit register access port decoded from the serial interface.
package kgd_pkg;
   // Register addresses on the access port
   localparam logic [3:0] KGD_ADDR_RAW = 4'h0; // Raw keypad result
   localparam logic [3:0] KGD_ADDR_STATUS = 4'h1; // Status keypad result
   localparam logic [3:0] KGD_ADDR_PENDING = 4'h2; // Pending keypad result
   localparam logic [3:0] KGD_ADDR_DAC = 4'h3; // DAC input value
   localparam logic [3:0] KGD_ADDR_GPIO = 4'h4; // GPIO pin data
   // Reset values
   localparam logic [15:0] KGD_RST_KEY = 16'h0000; // Keypad registers
   localparam logic [15:0] KGD_RST_DAC = 16'h1000; // DAC register, as a 16-bit word
   localparam logic [7:0] KGD_RST_GPIO = 8'h00; // GPIO output latch
   // Field positions
   localparam int KGD_DAC_LSB = 0; // DAC value in bits 7..0
   localparam int KGD_GPIO_LSB = 8; // GPIO data in bits 15..8
   localparam int KGD_KEYS_PER_COL = 4; // Rows per column
endpackage : kgd_pkg

// file: src/kgd_data_regs.sv
// Keypad result, DAC input and GPIO data registers of the keypad controller.
// Assumes a scanner delivering one key snapshot per pulse and a decoded register port.
//
// What this block does
// - Key bit index is 4*(col-1)+(row-1).
// - Raw register updates unless column masked.
// - Status bit blocked by key or column mask.
// - Pending ignores key mask; column mask blocks.
// - DAC value in bits 7..0, upper zero.
// - GPIO data in bits 15..8, lower zero.
// - GPIO read returns live pin levels.
// - GPIO write drives output pins only.
// - Writes to keypad results are ignored.
// - Reset clears registers; DAC starts 00H, the low byte of 1000H.
// - Select and enable make a GPIO output.
`timescale 1ns/1ps
module kgd_data_regs
   import kgd_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic scan_valid,
   input wire logic [15:0] scan_keys,
   input wire logic [15:0] per_key_mask_bit,
   input wire logic [3:0] column_mask_bit,
   input wire logic [7:0] pin_function_select,
   input wire logic [7:0] pin_output_enable,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   output logic [7:0] dac_value
);
   // All state of the block, registered as one word
   // Every field freezes together while ce is low
   typedef struct packed {
      logic [15:0] raw;
      logic [15:0] status;
      logic [15:0] pending;
      logic [7:0] dac;
      logic [7:0] gpio_out;
      logic [15:0] rdata;
   } kgd_state_t;

   kgd_state_t state_ff; // Registered state
   kgd_state_t nxt_state; // Next state
   // Decoded mask and direction views of the level inputs
   logic [15:0] col_block; // Keys blocked by their column mask
   logic [7:0] gpio_is_out; // Pins acting as GPIO outputs

   // Spread the four column mask bits over the sixteen key bits
   function automatic logic [15:0] kgd_col_expand(input logic [3:0] cm);
      logic [15:0] r;
      r = '0;
      // Four keys per column, rows counting up
      for (int i = 0; i < 16; i++) begin
         r[i] = cm[i / KGD_KEYS_PER_COL];
      end
      return r;
   endfunction : kgd_col_expand

   // Compose a read word for an address
   function automatic logic [15:0] kgd_read(input logic [3:0] a, input kgd_state_t s, input logic [7:0] pins);
      logic [15:0] r;
      r = '0;
      // Unmapped addresses read as zero
      unique case (a)
         KGD_ADDR_RAW: r = s.raw;
         KGD_ADDR_STATUS: r = s.status;
         KGD_ADDR_PENDING: r = s.pending;
         KGD_ADDR_DAC: r[KGD_DAC_LSB +: 8] = s.dac;
         KGD_ADDR_GPIO: r[KGD_GPIO_LSB +: 8] = pins;
         default: r = '0;
      endcase
      return r;
   endfunction : kgd_read

   // Column mask bit 0 is column 1, holding keys 0..3
   assign col_block = kgd_col_expand(column_mask_bit);
   // Selected as GPIO and enabled as output
   assign gpio_is_out = pin_function_select & pin_output_enable;

   // Next-state logic
   // Starts from the held state, so a field not named below keeps its value
   // Order matters: scan, then pending clear, then pending set, then writes
   always_comb begin
      // Default is hold
      nxt_state = state_ff;
      if (scan_valid) begin
         // A set scan bit means pressed
         for (int i = 0; i < 16; i++) begin
            if (!col_block[i]) begin
               nxt_state.raw[i] = scan_keys[i];
            end
            if (!col_block[i] && !per_key_mask_bit[i]) begin
               nxt_state.status[i] = scan_keys[i];
            end
         end
      end
      // Pending clears on its read; a new press wins over the clear
      if (reg_rd && reg_addr == KGD_ADDR_PENDING) begin
         nxt_state.pending = '0;
      end
      if (scan_valid) begin
         nxt_state.pending = nxt_state.pending | (scan_keys & ~col_block);
      end
      // Writes; keypad result addresses fall through untouched
      // The key results are owned by the scanner; only a read of pending also clears pending
      if (reg_wr) begin
         unique case (reg_addr)
            KGD_ADDR_DAC: nxt_state.dac = reg_wdata[KGD_DAC_LSB +: 8];
            KGD_ADDR_GPIO: begin
               // Only output pins take the written bit
               nxt_state.gpio_out = (state_ff.gpio_out & ~gpio_is_out)
                                  | (reg_wdata[KGD_GPIO_LSB +: 8] & gpio_is_out);
            end
            default: nxt_state.gpio_out = state_ff.gpio_out;
         endcase
      end
      // Read data captured one cycle after the strobe
      // Reads see the state before this edge, so a same-cycle write is not seen yet
      if (reg_rd) begin
         nxt_state.rdata = kgd_read(reg_addr, state_ff, pin_in);
      end
   end

   // State register with clock enable
   // Reset loads constants only; the DAC keeps just the low byte of its reset word
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_ff.raw <= KGD_RST_KEY;
         state_ff.status <= KGD_RST_KEY;
         state_ff.pending <= KGD_RST_KEY;
         state_ff.dac <= KGD_RST_DAC[KGD_DAC_LSB +: 8];
         state_ff.gpio_out <= KGD_RST_GPIO;
         state_ff.rdata <= KGD_RST_KEY;
      end else if (ce) begin
         state_ff <= nxt_state;
      end
   end

   // Outputs; data come straight from flip-flops
   // Output enable is decoded live from the level inputs
   assign reg_rdata = state_ff.rdata;
   assign dac_value = state_ff.dac;
   assign pin_out = state_ff.gpio_out;
   assign pin_oe = gpio_is_out;

   // Checks, sampled on the rising clock, idle while reset is high
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // Raw register: column mask blocks, per-key mask does not

   // Column 2 masked leaves keys 4..7 as they were
   a_raw_col_block: assert property (ce && scan_valid && column_mask_bit[1] |=>
      state_ff.raw[7:4] == $past(state_ff.raw[7:4])) else $error("raw updated in masked column");
   // Column 4 open takes the snapshot of keys 12..15
   a_raw_update: assert property (ce && scan_valid && !column_mask_bit[3] |=>
      state_ff.raw[15:12] == $past(scan_keys[15:12])) else $error("raw missed column 4 keys");
   // A key mask on key 0 does not stop the raw copy
   a_raw_key_free: assert property (ce && scan_valid && per_key_mask_bit[0] && !column_mask_bit[0] |=>
      state_ff.raw[0] == $past(scan_keys[0])) else $error("raw blocked by key mask");

   // Status register: either mask blocks

   // Key mask on key 0 holds its status bit
   a_status_mask: assert property (ce && scan_valid && per_key_mask_bit[0] |=>
      state_ff.status[0] == $past(state_ff.status[0])) else $error("status updated under key mask");
   // Column 2 masked holds status keys 4..7
   a_status_col_block: assert property (ce && scan_valid && column_mask_bit[1] |=>
      state_ff.status[7:4] == $past(state_ff.status[7:4])) else $error("status updated in masked column");
   // Unmasked key 8 follows the scan, pressed as 1
   a_status_update: assert property (ce && scan_valid && !per_key_mask_bit[8] && !column_mask_bit[2] |=>
      state_ff.status[8] == $past(scan_keys[8])) else $error("status missed key 8");

   // Pending register: sticky presses, column mask only

   // A press in an open column is caught
   a_pending_set: assert property (ce && scan_valid && scan_keys[11] && !column_mask_bit[2] |=>
      state_ff.pending[11]) else $error("pending missed a press");
   // The key mask does not stop a pending press
   a_pending_key_free: assert property (ce && scan_valid && scan_keys[0] && per_key_mask_bit[0] &&
      !column_mask_bit[0] |=> state_ff.pending[0]) else $error("pending blocked by key mask");
   // Column 2 masked holds pending keys 4..7 unless a read clears them
   a_pending_col_block: assert property (ce && scan_valid && column_mask_bit[1] &&
      !(reg_rd && reg_addr == KGD_ADDR_PENDING) |=>
      state_ff.pending[7:4] == $past(state_ff.pending[7:4])) else $error("pending updated in masked column");

   // Read port

   // DAC word has zeros above its byte
   a_dac_upper: assert property (ce && reg_rd && reg_addr == KGD_ADDR_DAC |=>
      reg_rdata[15:8] == 8'h00 && reg_rdata[7:0] == $past(state_ff.dac)) else $error("dac read wrong");
   // GPIO word carries live pin levels in the top byte
   a_gpio_read: assert property (ce && reg_rd && reg_addr == KGD_ADDR_GPIO |=>
      reg_rdata == {$past(pin_in), 8'h00}) else $error("gpio read not pin levels");
   // Read data stands until the next taken read
   a_rdata_hold: assert property (ce && !reg_rd |=>
      reg_rdata == $past(reg_rdata)) else $error("read data changed without a read");

   // Write port

   // An input pin does not take written data
   a_gpio_input_hold: assert property (ce && reg_wr && reg_addr == KGD_ADDR_GPIO && !gpio_is_out[2] |=>
      pin_out[2] == $past(pin_out[2])) else $error("input pin latched written data");
   // An output pin drives the written bit
   a_gpio_out_drive: assert property (ce && reg_wr && reg_addr == KGD_ADDR_GPIO && gpio_is_out[0] |=>
      pin_out[0] == $past(reg_wdata[KGD_GPIO_LSB])) else $error("output pin missed written data");
   // Writes to a key result leave it alone
   a_key_write_ignored: assert property (ce && reg_wr && reg_addr == KGD_ADDR_RAW && !scan_valid |=>
      state_ff.raw == $past(state_ff.raw)) else $error("raw changed on write");

   // Clock enable low freezes every register
   a_ce_freeze: assert property (!ce |=>
      state_ff == $past(state_ff)) else $error("state moved with clock enable low");

   // Main scenarios reached
   c_scan_masked: cover property (ce && scan_valid && |column_mask_bit);
   c_pending_clear: cover property (ce && reg_rd && reg_addr == KGD_ADDR_PENDING ##1 reg_rdata != 16'h0000);
   c_gpio_drive: cover property (ce && reg_wr && reg_addr == KGD_ADDR_GPIO && |gpio_is_out);
   c_ce_frozen: cover property (!ce && scan_valid);
   c_key_masked: cover property (ce && scan_valid && |(per_key_mask_bit & scan_keys));
endmodule : kgd_data_regs

// file: bench/kgd_pin_model.sv
// Pin model for the keypad row and column lines seen by the data registers.
// Assumes the block's pin_out and pin_oe, and an outside level set by the bench.
`timescale 1ns/1ps
module kgd_pin_model (
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] ext_level,
   output logic [7:0] pin_level
);
   // Driven pins show the block's value, the others the outside level
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : kgd_pin_model

// file: bench/tb_keypad_gpio_data_regs.sv
// Self-checking bench for the keypad, DAC and GPIO data registers.
// Assumes kgd_pkg, kgd_data_regs and the pin model; ce stays high except in test_ce.
`timescale 1ns/1ps
module tb_keypad_gpio_data_regs;
   import kgd_pkg::*;
   logic clk = 1'b0, reset = 1'b1, ce = 1'b1, scan_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [15:0] scan_keys = 16'h0000, per_key_mask_bit = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
   logic [3:0] column_mask_bit = 4'h0, reg_addr = 4'h0;
   logic [7:0] pin_function_select = 8'h00, pin_output_enable = 8'h00, ext_level = 8'h00;
   logic [7:0] pin_in, pin_out, pin_oe, dac_value;
   int errors = 0, num_checks = 0;
   // 200 MHz clock
   always #2.5 clk = ~clk;
   kgd_data_regs dut_u (.clk(clk), .reset(reset), .ce(ce), .scan_valid(scan_valid), .scan_keys(scan_keys),
      .per_key_mask_bit(per_key_mask_bit), .column_mask_bit(column_mask_bit),
      .pin_function_select(pin_function_select), .pin_output_enable(pin_output_enable), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .dac_value(dac_value));
   kgd_pin_model pin_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_level(pin_in));
   // Verdict and end of run
   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict
   // Compare one value
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // One read, data judged the cycle after
   task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string nm);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(nm, exp, reg_rdata);
   endtask : rd
   // One write
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Values after reset, unmapped read
   task automatic test_reset;
      rd(KGD_ADDR_RAW, 16'h0000, "raw");
      rd(KGD_ADDR_STATUS, 16'h0000, "status");
      rd(KGD_ADDR_PENDING, 16'h0000, "pending");
      rd(KGD_ADDR_DAC, 16'h0000, "dac");
      rd(4'hf, 16'h0000, "unmapped");
   endtask : test_reset
   // Full-pad press with column 2 and key 0 masked
   task automatic test_keys;
      @(posedge clk);
      column_mask_bit <= 4'h2;
      per_key_mask_bit <= 16'h0001;
      scan_keys <= 16'hffff;
      scan_valid <= 1'b1;
      @(posedge clk);
      scan_valid <= 1'b0;
      rd(KGD_ADDR_RAW, 16'hff0f, "raw");
      rd(KGD_ADDR_STATUS, 16'hff0e, "status");
      wr(KGD_ADDR_RAW, 16'h0000);
      rd(KGD_ADDR_RAW, 16'hff0f, "raw kept");
      rd(KGD_ADDR_PENDING, 16'hff0f, "pending");
   endtask : test_keys
   // Only the low byte of a DAC write is kept
   task automatic test_dac;
      wr(KGD_ADDR_DAC, 16'hab5c);
      rd(KGD_ADDR_DAC, 16'h005c, "dac");
      chk("dac_value", 16'h005c, {8'h00, dac_value});
   endtask : test_dac
   // Rows as GPIO, rows 1 and 2 outputs
   task automatic test_gpio;
      @(posedge clk);
      pin_function_select <= 8'h0f;
      pin_output_enable <= 8'h33;
      ext_level <= 8'hc3;
      wr(KGD_ADDR_GPIO, 16'ha5ff);
      #1 chk("pin_oe", 16'h0003, {8'h00, pin_oe});
      chk("pin_out", 16'h0001, {8'h00, pin_out});
      rd(KGD_ADDR_GPIO, 16'hc100, "gpio");
      @(posedge clk);
      ext_level <= 8'h3c;
      rd(KGD_ADDR_GPIO, 16'h3d00, "gpio live");
   endtask : test_gpio
   // Clock enable low freezes scan and write; pending was cleared by its read
   task automatic test_ce;
      @(posedge clk);
      ce <= 1'b0;
      scan_keys <= 16'h0000;
      scan_valid <= 1'b1;
      @(posedge clk);
      scan_valid <= 1'b0;
      wr(KGD_ADDR_DAC, 16'h0011);
      @(posedge clk);
      ce <= 1'b1;
      rd(KGD_ADDR_RAW, 16'hff0f, "raw frozen");
      rd(KGD_ADDR_DAC, 16'h005c, "dac frozen");
      rd(KGD_ADDR_PENDING, 16'h0000, "pending cleared");
   endtask : test_ce
   // Reset in mid-run clears everything again
   task automatic test_reset_mid;
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      #1 chk("pin_out", 16'h0000, {8'h00, pin_out});
      chk("dac_value", 16'h0000, {8'h00, dac_value});
      chk("rdata", 16'h0000, reg_rdata);
      test_reset();
      rd(KGD_ADDR_GPIO, 16'h3c00, "gpio after reset");
   endtask : test_reset_mid
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      test_reset();
      test_keys();
      test_dac();
      test_gpio();
      test_ce();
      test_reset_mid();
      print_verdict();
   end
   // Watchdog
   initial begin
      #20000;
      errors++;
      print_verdict();
   end
endmodule : tb_keypad_gpio_data_regs
